/* File: design/tcsm_pkg.sv */
package tcsm_pkg;

	localparam int CNT_W = 16;

	// operation mode select codes
	localparam logic [2:0] MODE_INTERVAL = 3'h0;
	localparam logic [2:0] MODE_CAPTURE  = 3'h2;
	localparam logic [2:0] MODE_EVENT    = 3'h3;
	localparam logic [2:0] MODE_ONECOUNT = 3'h4;
	localparam logic [2:0] MODE_CAP_ONE  = 3'h6;

	localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
	localparam logic             TOUT_RESET = 1'b0;

	typedef struct packed {
		logic [2:0] operation_mode_select;
		logic       start_interrupt_select;
	} tcsm_mode_s;

	typedef enum logic [2:0] {
		TCSM_INTERVAL,
		TCSM_CAPTURE,
		TCSM_EVENT,
		TCSM_ONECOUNT,
		TCSM_CAP_ONE,
		TCSM_PROHIBITED
	} tcsm_kind_e;

	typedef enum logic {
		TCSM_IDLE,
		TCSM_COUNT
	} tcsm_state_e;

endpackage : tcsm_pkg

/* File: design/tcsm_channel.sv */
`timescale 1ns/1ps
// Functional notes
// - mode field decodes five legal modes, all other codes prohibited.
// - interval, capture or event mode, select 0: silent start.
// - interval, capture or event mode, select 1: start irq and toggle.
// - one-count, select 0: trigger ignored while counting, no irq.
// - one-count, select 1: trigger taken while counting, no irq.
// - capture plus one-count needs select 0: silent start, no retrigger.
module tcsm_channel #(
	parameter int CNT_W = tcsm_pkg::CNT_W
) (
	input  wire logic                 mclk,
	input  wire logic                 reset_n,
	input  wire tcsm_pkg::tcsm_mode_s channel_mode_register,
	input  wire logic                 enable,
	input  wire logic                 start_trigger,
	input  wire logic                 count_tick,
	input  wire logic                 capture_trigger,
	input  wire logic [CNT_W-1:0]     reload_value,
	output logic                      timer_irq,
	output logic                      timer_out,
	output logic                      counting,
	output logic                      mode_prohibited,
	output logic [CNT_W-1:0]          count_value,
	output logic [CNT_W-1:0]          capture_value
);

	tcsm_pkg::tcsm_state_e state_q;
	tcsm_pkg::tcsm_state_e state_d;
	tcsm_pkg::tcsm_kind_e  kind;
	logic [CNT_W-1:0]      cnt_q;
	logic [CNT_W-1:0]      cnt_d;
	logic [CNT_W-1:0]      cap_q;
	logic                  tout_q;
	logic                  irq_q;
	logic                  irq_d;
	logic                  tout_tgl;
	logic                  trig_sync_q;
	logic                  trig_meta_q;
	logic                  trig_prev_q;

	// the mode register is a level; a change acts on the next edge
	wire [2:0] mode_bits = channel_mode_register.operation_mode_select;
	wire       sel       = channel_mode_register.start_interrupt_select;

	always_comb
	begin
		case (mode_bits)
			tcsm_pkg::MODE_INTERVAL: kind = tcsm_pkg::TCSM_INTERVAL;
			tcsm_pkg::MODE_CAPTURE:  kind = tcsm_pkg::TCSM_CAPTURE;
			tcsm_pkg::MODE_EVENT:    kind = tcsm_pkg::TCSM_EVENT;
			tcsm_pkg::MODE_ONECOUNT: kind = tcsm_pkg::TCSM_ONECOUNT;
			tcsm_pkg::MODE_CAP_ONE:  kind = tcsm_pkg::TCSM_CAP_ONE;
			default:                 kind = tcsm_pkg::TCSM_PROHIBITED;
		endcase
	end

	wire is_interval = (kind == tcsm_pkg::TCSM_INTERVAL);
	wire is_capture  = (kind == tcsm_pkg::TCSM_CAPTURE);
	wire is_event    = (kind == tcsm_pkg::TCSM_EVENT);
	wire is_onecount = (kind == tcsm_pkg::TCSM_ONECOUNT);
	wire is_capone   = (kind == tcsm_pkg::TCSM_CAP_ONE);
	wire is_prohib   = (kind == tcsm_pkg::TCSM_PROHIBITED);

	// free modes start on enable alone; one-shot modes wait for a trigger
	wire is_free     = is_interval || is_capture || is_event;
	wire is_oneshot  = is_onecount || is_capone;
	// capture modes are the only ones that latch the count
	wire cap_mode    = is_capture || is_capone;
	// capture plus one-count with select 1 is treated as prohibited
	wire bad_cap1    = is_capone && sel;
	wire prohib      = is_prohib || bad_cap1;

	// start trigger is an external pin: two flops before any logic reads it
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			trig_meta_q <= 1'b0;
			trig_sync_q <= 1'b0;
		end
		else
		begin
			trig_meta_q <= start_trigger;
			trig_sync_q <= trig_meta_q;
		end
	end

	// history resets to the idle pin level: no false edge after reset
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			trig_prev_q <= 1'b0;
		else
			trig_prev_q <= trig_sync_q;
	end

	wire trig_rise  = trig_sync_q && !trig_prev_q;
	wire idle       = (state_q == tcsm_pkg::TCSM_IDLE);
	wire start_now  = enable && !prohib && idle
		&& (is_free ? 1'b1 : trig_rise);
	// a prohibited code or a dropped enable halts the channel at once
	wire halt       = !enable || prohib;
	// trigger ignored while counting unless one-count with select set
	// retrigger accepted only in plain one-count with select 1
	wire retrig     = enable && !idle && trig_rise && is_onecount && sel;
	wire at_zero    = (cnt_q == '0);
	wire expire     = !idle && count_tick && at_zero;
	wire do_capture = !idle && capture_trigger && cap_mode;
	// the start event only reports itself in the free modes
	wire start_irq  = is_free && sel;
	// zero expires on its tick, so the count never wraps below zero
	wire [CNT_W-1:0] cnt_dec = cnt_q - 1'b1;

	always_comb
	begin
		state_d  = state_q;
		cnt_d    = cnt_q;
		irq_d    = 1'b0;
		tout_tgl = 1'b0;
		case (state_q)
			tcsm_pkg::TCSM_IDLE:
			begin
				if (start_now)
				begin
					state_d = tcsm_pkg::TCSM_COUNT;
					cnt_d   = reload_value;
					// silent start when select is 0
					if (start_irq)
					begin
						irq_d    = 1'b1;
						tout_tgl = 1'b1;
					end
				end
			end
			tcsm_pkg::TCSM_COUNT:
			begin
				// halt wins, then a retrigger, then an expiry
				if (halt)
					state_d = tcsm_pkg::TCSM_IDLE;
				else if (retrig)
				begin
					cnt_d = reload_value;
				end
				else if (expire)
				begin
					irq_d    = 1'b1;
					tout_tgl = 1'b1;
					cnt_d    = reload_value;
					// one-shot modes stop after one period
					if (is_oneshot)
						state_d = tcsm_pkg::TCSM_IDLE;
				end
				else if (count_tick)
					cnt_d = cnt_dec;
			end
			default:
				state_d = tcsm_pkg::TCSM_IDLE;
		endcase
	end

	// output flips only on a start or an expiry event
	wire tout_d = tout_q ^ tout_tgl;

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			state_q <= tcsm_pkg::TCSM_IDLE;
		else
			state_q <= state_d;
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			cnt_q <= tcsm_pkg::CNT_RESET;
		else
			cnt_q <= cnt_d;
	end

	// interrupt is a one-cycle pulse per event; events on consecutive cycles hold it high
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			irq_q <= 1'b0;
		else
			irq_q <= irq_d;
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			tout_q <= tcsm_pkg::TOUT_RESET;
		else
			tout_q <= tout_d;
	end

	// capture keeps the last count seen at a capture trigger
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			cap_q <= tcsm_pkg::CNT_RESET;
		else if (do_capture)
			cap_q <= cnt_q;
	end

	// counting and the mode flag come straight from state and decode
	assign timer_irq       = irq_q;
	assign timer_out       = tout_q;
	assign counting        = !idle;
	assign mode_prohibited = prohib;
	assign count_value     = cnt_q;
	assign capture_value   = cap_q;

endmodule : tcsm_channel

/* File: sim/tcsm_channel_asserts.sv */
`timescale 1ns/1ps
module tcsm_asserts #(
	parameter int CNT_W = 16
) (
	input wire logic	mclk,
	input wire logic	reset_n,
	input wire tcsm_pkg::tcsm_mode_s	channel_mode_register,
	input wire logic [CNT_W-1:0]	reload_value,
	input wire logic	timer_irq,
	input wire logic	timer_out,
	input wire logic	counting,
	input wire logic	mode_prohibited,
	input wire logic [CNT_W-1:0]	count_value
);
	wire [2:0] m = channel_mode_register.operation_mode_select;
	wire s = channel_mode_register.start_interrupt_select;
	wire fr = m == 3'h0 || m == 3'h2 || m == 3'h3;
	wire os = m == 3'h4 || m == 3'h6;
	wire bad = !(fr || m == 3'h4 || (m == 3'h6 && !s));
	logic [CNT_W-1:0] cnt_prev_q;
	always_ff @(posedge mclk)
		cnt_prev_q <= count_value;
	// a rise in count while counting can only be a reload
	wire up = count_value > cnt_prev_q;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!reset_n);
	a_mode_decode: assert property (mode_prohibited == bad)
		else $error("bad flag");
	a_start_quiet: assert property (fr && !s && $rose(counting)
		|-> !timer_irq && $stable(timer_out)) else $error("start irq");
	a_start_irq: assert property (fr && s && $rose(counting)
		|-> timer_irq && $changed(timer_out)) else $error("no irq");
	a_hold_count: assert property (os && !s && counting
		&& $past(counting) |-> !up) else $error("retrig taken");
	a_retrig_quiet: assert property (m == 3'h4 && s && counting
		&& $past(counting) && up |-> !timer_irq) else $error("irq");
	a_capone_quiet: assert property (m == 3'h6 && $rose(counting)
		|-> !timer_irq && $stable(timer_out)) else $error("start irq");
	a_capone_sel: assert property (m == 3'h6 && s |=> !counting)
		else $error("runs");
	a_retrig_load: assert property (os && counting
		&& $past(counting) && up |-> count_value == reload_value)
		else $error("bad reload");
endmodule : tcsm_asserts
bind tcsm_channel tcsm_asserts #(.CNT_W(CNT_W)) tcsm_asserts_inst (
	.mclk, .reset_n, .channel_mode_register, .reload_value,
	.timer_irq, .timer_out, .counting, .mode_prohibited, .count_value
);

/* File: sim/tb_timer_channel_start_mode_control.sv */
`timescale 1ns/1ps
module tb_timer_channel_start_mode_control;
	logic mclk = 0, reset_n = 0, enable = 0, start_trigger = 0;
	logic count_tick = 0, timer_irq, timer_out, counting, mode_prohibited;
	logic capture_trigger = 0;
	tcsm_pkg::tcsm_mode_s cm = 4'h0;
	logic [15:0] reload_value = 16'h0005, count_value, capture_value;
	logic [2:0] md [3] = '{3'h0, 3'h2, 3'h3};
	int num_errors = 0, num_checks = 0;
	always #2 mclk = ~mclk;
	tcsm_channel tcsm_channel_inst (.mclk, .reset_n,
		.channel_mode_register(cm), .enable, .start_trigger, .count_tick,
		.capture_trigger, .reload_value, .timer_irq, .timer_out,
		.counting, .mode_prohibited, .count_value, .capture_value);
	task wrap_up();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up
	task chk(string n, logic [15:0] e, logic [15:0] g);
		num_checks++;
		if (e !== g)
		begin
			$display("unexpected %s exp %h got %h", n, e, g);
			num_errors++;
		end
	endtask : chk
	task cyc(int n);
		repeat (n) @(posedge mclk);
	endtask : cyc
	// bounded wait for a start; sampled after the edge's updates land
	task wt();
		int i;
		for (i = 0; i < 20; i++)
		begin
			@(posedge mclk);
			#1;
			if (counting === 1'b1)
				break;
		end
		if (counting !== 1'b1)
		begin
			num_errors++;
			wrap_up();
		end
	endtask : wt
	task t_decode();
		int k;
		for (k = 0; k < 16; k++)
		begin
			@(posedge mclk);
			cm <= k[3:0];
			@(posedge mclk);
			#1;
			chk("prohib", !(k inside {[0:1], [4:9], 12}), mode_prohibited);
		end
		$display("decode done");
	endtask : t_decode
	task t_free();
		int k;
		logic t;
		for (k = 0; k < 6; k++)
		begin
			t = timer_out;
			@(posedge mclk);
			cm <= {md[k/2], k[0]};
			enable <= 1'b1;
			wt();
			chk("irq", k[0], timer_irq);
			chk("tout", t ^ k[0], timer_out);
			@(posedge mclk);
			enable <= 1'b0;
			cyc(3);
		end
		$display("free start done");
	endtask : t_free
	task t_cap();
		@(posedge mclk);
		cm <= 4'h4;
		enable <= 1'b1;
		wt();
		@(posedge mclk);
		count_tick <= 1'b1;
		cyc(2);
		count_tick <= 1'b0;
		capture_trigger <= 1'b1;
		@(posedge mclk);
		capture_trigger <= 1'b0;
		cyc(2);
		#1;
		chk("capture", 16'h0003, capture_value);
		@(posedge mclk);
		enable <= 1'b0;
		cyc(3);
		$display("capture done");
	endtask : t_cap
	task t_one();
		int k;
		for (k = 0; k < 3; k++)
		begin
			@(posedge mclk);
			cm <= {k < 2 ? 3'h4 : 3'h6, k == 1};
			enable <= 1'b1;
			start_trigger <= 1'b1;
			cyc(2);
			start_trigger <= 1'b0;
			wt();
			@(posedge mclk);
			count_tick <= 1'b1;
			cyc(2);
			count_tick <= 1'b0;
			start_trigger <= 1'b1;
			cyc(2);
			start_trigger <= 1'b0;
			cyc(5);
			#1;
			chk("count", k == 1 ? 16'h0005 : 16'h0003, count_value);
			@(posedge mclk);
			cm <= 4'h2;
			enable <= 1'b0;
		end
		$display("retrigger done");
	endtask : t_one
	initial
	begin
		cyc(4);
		reset_n <= 1'b1;
		t_decode();
		t_free();
		t_cap();
		t_one();
		wrap_up();
	end
endmodule : tb_timer_channel_start_mode_control
